// file: rtl/psr_pkg.sv
// Package of offsets, field positions, reset values and types for the PCS state/ability registers
package psr_pkg;

    // Management port geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // Word offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_STATE  = 5'h01;
    localparam logic [ADDR_W-1:0] OFS_LOCAL  = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_REMOTE = 5'h05;
    localparam logic [ADDR_W-1:0] OFS_IFMODE = 5'h14;

    // State report field positions
    localparam int ST_EXT_CAP     = 0;
    localparam int ST_BABBLE      = 1;
    localparam int ST_LINK        = 2;
    localparam int ST_AN_ABLE     = 3;
    localparam int ST_REM_FAULT   = 4;
    localparam int ST_AN_DONE     = 5;
    localparam int ST_MGMT_PRE    = 6;
    localparam int ST_UNIDIR      = 7;
    localparam int ST_EXT_STAT    = 8;
    localparam int ST_LEGACY_LO   = 9;
    localparam int ST_LEGACY_HI   = 15;

    // Ability word field positions, 1000BASE-X layout
    localparam int AB_FULL_DUP    = 5;
    localparam int AB_HALF_DUP    = 6;
    localparam int AB_PAUSE_SYM   = 7;
    localparam int AB_PAUSE_ASYM  = 8;
    localparam int AB_FAULT_HI    = 12;
    localparam int AB_FAULT_LO    = 13;
    localparam int AB_ACK         = 14;
    localparam int AB_EXTRA_PAGE  = 15;

    // Control and interface-mode field positions
    localparam int CT_AN_RESTART  = 9;
    localparam int CT_AN_ENABLE   = 12;
    localparam int IF_SGMII       = 0;

    // Values after reset
    localparam logic [DATA_W-1:0] LOCAL_RST   = 16'h0020;
    localparam logic [DATA_W-1:0] REMOTE_RST  = 16'h0000;
    localparam logic              AN_EN_RST   = 1'h1;
    localparam logic              SGMII_RST   = 1'h0;

    // Identical ability words in a row needed for acknowledge
    localparam logic [1:0]        MATCH_NEED  = 2'h3;

    // Negotiation tracking, Gray coded along the usual path
    typedef enum logic [1:0] {
        AN_IDLE      = 2'h0,
        AN_WAIT_ACK  = 2'h1,
        AN_WAIT_DONE = 2'h3,
        AN_COMPLETE  = 2'h2
    } psr_an_state_t;

endpackage

// file: rtl/psr_ability_match.sv
// Consecutive-match detector that captures the link partner ability word
`timescale 1ns/1ps
module psr_ability_match
    import psr_pkg::*;
(
    // Clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_resetn,
    // Control
    input  wire logic              i_clear,
    // Received ability words
    input  wire logic              i_word_vld,
    input  wire logic [DATA_W-1:0] i_word,
    // Result
    output logic                   o_ack,
    output logic [DATA_W-1:0]      o_word
);

    logic [DATA_W-1:0] last_reg;
    logic [1:0]        cnt_reg;
    logic [1:0]        cnt_next;
    logic              same;
    logic              hit;

    assign same     = (i_word == last_reg) && (cnt_reg != 2'h0);
    assign cnt_next = !same ? 2'h1 : (cnt_reg == MATCH_NEED) ? MATCH_NEED : cnt_reg + 2'h1;
    assign hit      = i_word_vld && (cnt_next == MATCH_NEED);

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            last_reg <= REMOTE_RST;
            cnt_reg  <= 2'h0;
        end else if (i_clear) begin
            cnt_reg  <= 2'h0;
        end else if (i_word_vld) begin
            last_reg <= i_word;
            cnt_reg  <= cnt_next;
        end
    end

    // Partner word only changes on a confirmed value, so software never sees a glitch word
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_ack  <= 1'h0;
            o_word <= REMOTE_RST;
        end else if (i_clear) begin
            o_ack  <= 1'h0;
        end else if (hit) begin
            o_ack  <= 1'h1;
            o_word <= i_word;
        end
    end

endmodule

// file: rtl/psr_regs.sv
// PCS state report and auto-negotiation ability register bank
//
// Overview of operation
// - Link bit reads 1 on valid link; a loss latches 0 until read.
// - Extended-capability bit always reads 1.
// - Negotiation-ability bit always reads 1.
// - Babble, remote-fault, preamble-skip and extended-status bits always read 0.
// - Bit 5 reads 1 only after negotiation finished with valid results.
// - Bit 7 reports ability to transmit without a valid link.
// - Bits 9 to 15 of the state report always read 0.
// - Ability words count as meaningful only while negotiation is complete.
// - Partner layout depends on mode; in 1000BASE-X both words share one layout.
// - Ability bit 5 is full duplex, bit 6 half duplex.
// - Ability bits 7 and 8 form the pause field.
// - Ability bits 12 and 13 encode the remote fault condition.
// - Partner ability bit 14 is read-only acknowledge after three matching partner words.
// - Local next-page bit always 0; next-page operation never advertised.
// - Local word read/write except next page; partner word read-only from the partner.
// - Interface mode selects 1000BASE-X or SGMII and thus the ability layout; only the 1000BASE-X layout is decoded.
// - Writing 1 to control bit 9 restarts negotiation; completion tracks the new run.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module psr_regs
    import psr_pkg::*;
(
    // Clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_resetn,
    // Management register port
    input  wire logic [ADDR_W-1:0] i_reg_addr,
    input  wire logic [DATA_W-1:0] i_reg_wdata,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    output logic      [DATA_W-1:0] o_reg_rdata,
    // PCS datapath status
    input  wire logic              i_link_sync,
    input  wire logic              i_unidir_able,
    input  wire logic              i_an_done,
    // Ability words received from the link partner
    input  wire logic              i_rx_ability_vld,
    input  wire logic [DATA_W-1:0] i_rx_ability,
    // Negotiation control toward the PCS
    output logic                   o_an_restart,
    output logic                   o_an_enable,
    output logic                   o_sgmii_mode,
    output logic      [DATA_W-1:0] o_local_ability,
    // Negotiation completion, and resolved partner abilities (1000BASE-X only)
    output logic                   o_an_complete,
    output logic                   o_partner_full_dup_cap,
    output logic                   o_partner_half_dup_cap,
    output logic      [1:0]        o_partner_pause,
    output logic      [1:0]        o_partner_fault
);

    // Address decode
    // Full five-bit compare, so reserved offsets alias nothing;
    // writes to them are dropped and reads return zero
    wire sel_ctrl   = (i_reg_addr == OFS_CTRL);
    wire sel_state  = (i_reg_addr == OFS_STATE);
    wire sel_local  = (i_reg_addr == OFS_LOCAL);
    wire sel_remote = (i_reg_addr == OFS_REMOTE);
    wire sel_ifmode = (i_reg_addr == OFS_IFMODE);

    wire wr_ctrl    = i_reg_wr && sel_ctrl;
    wire wr_local   = i_reg_wr && sel_local;
    wire wr_ifmode  = i_reg_wr && sel_ifmode;
    wire rd_state   = i_reg_rd && sel_state;

    // Restart request written by software
    wire restart_req = wr_ctrl && i_reg_wdata[CT_AN_RESTART];

    // Registers
    logic                   link_latch_reg;
    logic                   link_latch_next;
    logic                   an_en_reg;
    logic                   sgmii_reg;
    logic [DATA_W-1:0]      local_reg;
    logic [DATA_W-1:0]      local_next;
    logic                   restart_reg;
    logic [DATA_W-1:0]      rdata_reg;
    logic [DATA_W-1:0]      rdata_next;
    psr_an_state_t          an_state_reg;
    psr_an_state_t          an_state_next;

    // Partner word capture
    logic                   ack;
    logic [DATA_W-1:0]      remote_word;
    logic                   match_clear;

    // Latched-low link: a read reloads the live value, otherwise any loss sticks.
    // A loss in the same cycle as the read still wins, so a dropout is never
    // lost between the read and the reload. The read returns the value held
    // before the reload, which is what the software has not yet seen.
    assign link_latch_next = rd_state ? i_link_sync
                                      : (link_latch_reg && i_link_sync);

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            link_latch_reg <= 1'h0;
        end else begin
            link_latch_reg <= link_latch_next;
        end
    end

    // Negotiation enable; clearing it parks the tracker in idle and drops any result
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            an_en_reg <= AN_EN_RST;
        end else if (wr_ctrl) begin
            an_en_reg <= i_reg_wdata[CT_AN_ENABLE];
        end
    end

    // Interface mode; only the 1000BASE-X layout is decoded, SGMII leaves the
    // partner outputs at zero so a change to SGMII never shows a misread field
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sgmii_reg <= SGMII_RST;
        end else if (wr_ifmode) begin
            sgmii_reg <= i_reg_wdata[IF_SGMII];
        end
    end

    // Restart is self-clearing: one pulse per write of 1
    // The bit itself reads back as zero, so software never has to clear it;
    // a second write of 1 simply starts another run
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            restart_reg <= 1'h0;
        end else begin
            restart_reg <= restart_req;
        end
    end

    // Local ability: every bit writable except next page, which stays clear
    // Reserved bits are kept as written; keeping them zero is up to software
    always_comb begin
        local_next = local_reg;
        if (wr_local) begin
            local_next = i_reg_wdata;
            local_next[AB_EXTRA_PAGE] = 1'h0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            local_reg <= LOCAL_RST;
        end else begin
            local_reg <= local_next;
        end
    end

    // Negotiation tracking; a restart or lost sync discards any earlier result
    wire an_abort = restart_req || !an_en_reg || !i_link_sync;

    // Matcher is held clear in idle so stale words from a dead link never count
    assign match_clear = restart_req || (an_state_reg == AN_IDLE);

    always_comb begin
        an_state_next = an_state_reg;
        case (an_state_reg)
            // Listen to the partner only once sync and enable are both present
            AN_IDLE: begin
                if (an_en_reg && i_link_sync) begin
                    an_state_next = AN_WAIT_ACK;
                end
            end
            // Three identical partner words in a row give the acknowledge
            AN_WAIT_ACK: begin
                if (ack) begin
                    an_state_next = AN_WAIT_DONE;
                end
            end
            // Result counts as valid only once the PCS reports the exchange done
            AN_WAIT_DONE: begin
                if (i_an_done) begin
                    an_state_next = AN_COMPLETE;
                end
            end
            // Hold the result until an abort
            AN_COMPLETE: begin
                an_state_next = AN_COMPLETE;
            end
            default: begin
                an_state_next = AN_IDLE;
            end
        endcase
        // Abort overrides every state, including a completion in the same cycle
        if (an_abort) begin
            an_state_next = AN_IDLE;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            an_state_reg <= AN_IDLE;
        end else begin
            an_state_reg <= an_state_next;
        end
    end

    // Completion is read straight from the tracker, never from a separate flag
    wire an_complete = (an_state_reg == AN_COMPLETE);

    // Partner word is loaded only from the link, never from the register port
    // A write to the partner offset has no decode at all, so it cannot land
    psr_ability_match u_match (
        .i_sys_clk  (i_sys_clk),
        .i_resetn   (i_resetn),
        .i_clear    (match_clear),
        .i_word_vld (i_rx_ability_vld),
        .i_word     (i_rx_ability),
        .o_ack      (ack),
        .o_word     (remote_word)
    );

    // State report word, assembled from constants and live state
    // Fixed bits are constants so no write can ever disturb them
    logic [DATA_W-1:0] state_word;

    always_comb begin
        state_word = 16'h0000;
        state_word[ST_EXT_CAP]   = 1'h1;
        state_word[ST_BABBLE]    = 1'h0;
        state_word[ST_LINK]      = link_latch_reg;
        state_word[ST_AN_ABLE]   = 1'h1;
        state_word[ST_REM_FAULT] = 1'h0;
        state_word[ST_AN_DONE]   = an_complete;
        state_word[ST_MGMT_PRE]  = 1'h0;
        state_word[ST_UNIDIR]    = i_unidir_able;
        state_word[ST_EXT_STAT]  = 1'h0;
        state_word[ST_LEGACY_HI:ST_LEGACY_LO] = 7'h00;
    end

    // Ack bit in the partner word shows the device's own acknowledge
    // The partner's own bit 14 is kept in the stored word but never shown
    logic [DATA_W-1:0] remote_view;

    always_comb begin
        remote_view = remote_word;
        remote_view[AB_ACK] = ack;
    end

    // Read mux; unmapped offsets read as zero, restart reads back as zero
    // Outside a read strobe the mux feeds zero, so data stand for one cycle only
    logic [DATA_W-1:0] ctrl_view;

    always_comb begin
        ctrl_view = 16'h0000;
        ctrl_view[CT_AN_ENABLE] = an_en_reg;
    end

    // Interface mode word: only the mode bit is implemented
    logic [DATA_W-1:0] ifmode_view;

    always_comb begin
        ifmode_view = 16'h0000;
        ifmode_view[IF_SGMII] = sgmii_reg;
    end

    always_comb begin
        rdata_next = 16'h0000;
        if (i_reg_rd) begin
            if (sel_ctrl) begin
                rdata_next = ctrl_view;
            end else if (sel_state) begin
                rdata_next = state_word;
            end else if (sel_local) begin
                rdata_next = local_reg;
            end else if (sel_remote) begin
                rdata_next = remote_view;
            end else if (sel_ifmode) begin
                rdata_next = ifmode_view;
            end else begin
                rdata_next = 16'h0000;
            end
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Decoded partner abilities: only meaningful in 1000BASE-X after completion
    wire decode_ok = an_complete && !sgmii_reg;

    // Partner fields in the 1000BASE-X layout
    wire       rx_full  = remote_word[AB_FULL_DUP];
    wire       rx_half  = remote_word[AB_HALF_DUP];
    wire [1:0] rx_pause = {remote_word[AB_PAUSE_SYM], remote_word[AB_PAUSE_ASYM]};
    wire [1:0] rx_fault = {remote_word[AB_FAULT_HI], remote_word[AB_FAULT_LO]};

    logic       p_full_reg;
    logic       p_half_reg;
    logic [1:0] p_pause_reg;
    logic [1:0] p_fault_reg;

    // Duplex abilities; held at zero whenever the result is not trustworthy
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            p_full_reg <= 1'h0;
            p_half_reg <= 1'h0;
        end else if (decode_ok) begin
            p_full_reg <= rx_full;
            p_half_reg <= rx_half;
        end else begin
            p_full_reg <= 1'h0;
            p_half_reg <= 1'h0;
        end
    end

    // Pause and remote fault codes as two-bit fields, with bits 7 and 12 as the high bit of each
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            p_pause_reg <= 2'h0;
            p_fault_reg <= 2'h0;
        end else if (decode_ok) begin
            p_pause_reg <= rx_pause;
            p_fault_reg <= rx_fault;
        end else begin
            p_pause_reg <= 2'h0;
            p_fault_reg <= 2'h0;
        end
    end

    // Outputs; the completion flag is a decode of the tracker state, so it
    // moves in the same cycle as status bit 5
    assign o_reg_rdata            = rdata_reg;
    assign o_an_restart           = restart_reg;
    assign o_an_enable            = an_en_reg;
    assign o_sgmii_mode           = sgmii_reg;
    assign o_local_ability        = local_reg;
    assign o_an_complete          = an_complete;
    assign o_partner_full_dup_cap = p_full_reg;
    assign o_partner_half_dup_cap = p_half_reg;
    assign o_partner_pause        = p_pause_reg;
    assign o_partner_fault        = p_fault_reg;

endmodule

// file: tb/psr_regs_props.sv
// Checker for the state report and ability register bank
`timescale 1ns/1ps
module psr_regs_props
    import psr_pkg::*;
(
    // Clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_resetn,
    // Register port
    input  wire logic [ADDR_W-1:0] i_reg_addr,
    input  wire logic [DATA_W-1:0] i_reg_wdata,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    input  wire logic [DATA_W-1:0] o_reg_rdata,
    // Status and negotiation
    input  wire logic              i_link_sync,
    input  wire logic              i_unidir_able,
    input  wire logic              o_an_restart,
    input  wire logic              o_sgmii_mode,
    input  wire logic [DATA_W-1:0] o_local_ability,
    input  wire logic              o_an_complete,
    input  wire logic              o_partner_full_dup_cap,
    input  wire logic [1:0]        o_partner_pause
);
    wire st_rd  = i_reg_rd && (i_reg_addr == OFS_STATE);
    wire rst_wr = i_reg_wr && (i_reg_addr == OFS_CTRL) && i_reg_wdata[CT_AN_RESTART];
    wire mapped = (i_reg_addr == OFS_CTRL) || (i_reg_addr == OFS_STATE) ||
                  (i_reg_addr == OFS_LOCAL) || (i_reg_addr == OFS_REMOTE) ||
                  (i_reg_addr == OFS_IFMODE);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // A loss seen before the read must show even if sync is back by then
    sequence s_loss_then_read;
        !i_link_sync ##1 st_rd;
    endsequence
    a_link_loss_latched: assert property (s_loss_then_read |=> !o_reg_rdata[ST_LINK])
        else $error("link loss not latched");
    a_fixed_state_bits: assert property (st_rd |=> (o_reg_rdata & 16'hFF5B) == 16'h0009)
        else $error("fixed state bits wrong");
    a_done_bit_read: assert property (st_rd |=> o_reg_rdata[ST_AN_DONE] == $past(o_an_complete))
        else $error("completion bit wrong");
    a_unidir_bit_read: assert property (st_rd |=> o_reg_rdata[ST_UNIDIR] == $past(i_unidir_able))
        else $error("unidirectional bit wrong");
    a_unmapped_read: assert property (i_reg_rd && !mapped |=> o_reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_local_np_zero: assert property (o_local_ability[AB_EXTRA_PAGE] == 1'b0)
        else $error("local next page set");
    a_local_write: assert property (i_reg_wr && i_reg_addr == OFS_LOCAL |=>
        o_local_ability == {1'b0, $past(i_reg_wdata[14:0])})
        else $error("local write lost");
    a_restart_pulse: assert property (rst_wr |=> o_an_restart && !o_an_complete)
        else $error("restart not taken");
    a_restart_quiet: assert property (!rst_wr |=> !o_an_restart)
        else $error("spurious restart");
    a_decode_gated: assert property ((!o_an_complete || o_sgmii_mode) |=>
        !o_partner_full_dup_cap && o_partner_pause == 2'h0)
        else $error("partner decode not gated");
endmodule

// file: tb/test_psr_regs.sv
// Self-checking bench for the state report and ability register bank
`timescale 1ns/1ps
module test_psr_regs
    import psr_pkg::*;
;
    logic              i_sys_clk        = 1'b0;
    logic              i_resetn         = 1'b0;
    logic [ADDR_W-1:0] i_reg_addr       = '0;
    logic [DATA_W-1:0] i_reg_wdata      = '0;
    logic              i_reg_wr         = 1'b0;
    logic              i_reg_rd         = 1'b0;
    logic              i_link_sync      = 1'b0;
    logic              i_unidir_able    = 1'b0;
    logic              i_an_done        = 1'b0;
    logic              i_rx_ability_vld = 1'b0;
    logic [DATA_W-1:0] i_rx_ability     = '0;
    logic [DATA_W-1:0] o_reg_rdata;
    logic              o_an_restart;
    logic              o_an_enable;
    logic              o_sgmii_mode;
    logic [DATA_W-1:0] o_local_ability;
    logic              o_an_complete;
    logic              o_partner_full_dup_cap;
    logic              o_partner_half_dup_cap;
    logic [1:0]        o_partner_pause;
    logic [1:0]        o_partner_fault;
    int                errors      = 0;
    int                check_count = 0;
    int                cyc         = 0;
    wire  [DATA_W-1:0] decode = {10'h000, o_partner_full_dup_cap, o_partner_half_dup_cap,
                                 o_partner_pause, o_partner_fault};

    psr_regs psr_regs_inst (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_link_sync(i_link_sync), .i_unidir_able(i_unidir_able),
        .i_an_done(i_an_done), .i_rx_ability_vld(i_rx_ability_vld),
        .i_rx_ability(i_rx_ability), .o_an_restart(o_an_restart), .o_an_enable(o_an_enable),
        .o_sgmii_mode(o_sgmii_mode), .o_local_ability(o_local_ability),
        .o_an_complete(o_an_complete), .o_partner_full_dup_cap(o_partner_full_dup_cap),
        .o_partner_half_dup_cap(o_partner_half_dup_cap), .o_partner_pause(o_partner_pause),
        .o_partner_fault(o_partner_fault)
    );

    always #4 i_sys_clk = ~i_sys_clk;

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Generous ceiling; the sequence needs well under a thousand cycles
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_sys_clk);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge i_sys_clk);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        #1;
        chk(o_reg_rdata, e);
    endtask

    task automatic send_word(input logic [DATA_W-1:0] w);
        @(posedge i_sys_clk);
        i_rx_ability_vld <= 1'b1;
        i_rx_ability     <= w;
        @(posedge i_sys_clk);
        i_rx_ability_vld <= 1'b0;
    endtask

    task automatic t_reset_values;
        chk(o_local_ability, LOCAL_RST);
        chk({15'h0, o_an_enable}, 16'h0001);
        chk({15'h0, o_sgmii_mode}, 16'h0000);
        rd_chk(OFS_LOCAL, LOCAL_RST);
        rd_chk(OFS_REMOTE, REMOTE_RST);
        rd_chk(OFS_CTRL, 16'h1000);
        rd_chk(OFS_IFMODE, 16'h0000);
    endtask

    task automatic t_state_and_link;
        i_unidir_able <= 1'b1;
        rd_chk(OFS_STATE, 16'h0089);
        i_unidir_able <= 1'b0;
        i_link_sync   <= 1'b1;
        rd_chk(OFS_STATE, 16'h0009);
        rd_chk(OFS_STATE, 16'h000D);
        @(posedge i_sys_clk);
        i_link_sync <= 1'b0;
        // Sync returns in the very cycle of the read strobe; the loss must still show
        fork
            rd_chk(OFS_STATE, 16'h0009);
            begin
                @(posedge i_sys_clk);
                i_link_sync <= 1'b1;
            end
        join
        rd_chk(OFS_STATE, 16'h000D);
    endtask

    task automatic t_access_kinds;
        wr_reg(OFS_LOCAL, 16'hFFFF);
        chk(o_local_ability, 16'h7FFF);
        rd_chk(OFS_LOCAL, 16'h7FFF);
        wr_reg(OFS_STATE, 16'hFFFF);
        wr_reg(OFS_REMOTE, 16'hFFFF);
        wr_reg(5'h1F, 16'hFFFF);
        rd_chk(OFS_STATE, 16'h000D);
        rd_chk(OFS_REMOTE, 16'h0000);
        rd_chk(5'h1F, 16'h0000);
        wr_reg(OFS_LOCAL, 16'h01E0);
        rd_chk(OFS_LOCAL, 16'h01E0);
    endtask

    // One negotiation per pause and fault code, each preceded by a restart
    task automatic t_negotiate;
        logic [1:0]        k;
        logic [DATA_W-1:0] w;
        for (int i = 0; i < 4; i++) begin
            k = i[1:0];
            w = {2'b00, k[0], k[1], 3'b000, k[0], k[1], k[0], 1'b1, 5'h00};
            wr_reg(OFS_CTRL, 16'h1200);
            chk({15'h0, o_an_restart}, 16'h0001);
            chk({15'h0, o_an_complete}, 16'h0000);
            send_word(w ^ 16'h0020);
            send_word(w);
            send_word(w);
            if (i == 0) rd_chk(OFS_REMOTE, 16'h0000);
            send_word(w);
            rd_chk(OFS_REMOTE, w | 16'h4000);
            chk(decode, 16'h0000);
            @(posedge i_sys_clk);
            i_an_done <= 1'b1;
            @(posedge i_sys_clk);
            i_an_done <= 1'b0;
            repeat (2) @(posedge i_sys_clk);
            #1;
            chk({15'h0, o_an_complete}, 16'h0001);
            chk(decode, {10'h000, 1'b1, k[0], k[1], k[0], k[1], k[0]});
            rd_chk(OFS_STATE, 16'h002D);
        end
        wr_reg(OFS_IFMODE, 16'h0001);
        chk({15'h0, o_sgmii_mode}, 16'h0001);
        repeat (2) @(posedge i_sys_clk);
        #1;
        chk(decode, 16'h0000);
        wr_reg(OFS_CTRL, 16'h0000);
        chk({15'h0, o_an_enable}, 16'h0000);
        // The tracker idles one edge after the write and the acknowledge one edge later
        @(posedge i_sys_clk);
        rd_chk(OFS_REMOTE, w);
        chk({15'h0, o_an_complete}, 16'h0000);
    endtask

    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        #1;
        t_reset_values();
        t_state_and_link();
        t_access_kinds();
        t_negotiate();
        tally_and_finish();
    end
endmodule

bind psr_regs psr_regs_props psr_regs_props_inst (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_link_sync(i_link_sync), .i_unidir_able(i_unidir_able),
    .o_an_restart(o_an_restart), .o_sgmii_mode(o_sgmii_mode),
    .o_local_ability(o_local_ability), .o_an_complete(o_an_complete),
    .o_partner_full_dup_cap(o_partner_full_dup_cap), .o_partner_pause(o_partner_pause)
);
